// ===== smso_pkg.sv
// constants shared by the shaft motion status block
package smso_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_MOTION = 12'h000;
   localparam logic [11:0] OFF_HEADING = 12'h004;
   localparam logic [11:0] OFF_COUNT = 12'h008;
   localparam logic [11:0] OFF_CONFIG = 12'h00C;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int SHAFTS = 5;
   localparam int COUNT_W = 4;
   localparam int COUNT_LSB = 0;
   localparam int FLAG_LSB = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] FLAG_RESET = 5'h00;
   localparam logic [3:0] COUNT_RESET = 4'h5;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // bus answer state
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      SMSO_IDLE = 1'b0,
      SMSO_ANSWER = 1'b1
   } smso_bus_state_type;

endpackage : smso_pkg

// ===== smso_shaft_track.sv
// per-shaft moving and heading flag tracker
`timescale 1ns/1ps
`default_nettype none

module smso_shaft_track (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [4:0] move_active,
   input wire logic [4:0] move_fwd,
   input wire logic [4:0] enable_mask,
   output logic [4:0] moving_reg,
   output logic [4:0] heading_reg
);

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   logic [4:0] moving_next;
   logic [4:0] heading_next;

   assign moving_next = move_active & enable_mask;

   assign heading_next = (move_active & move_fwd) | (~move_active & heading_reg);

   // ----------------------------------------------------------------
   // flag registers
   // ----------------------------------------------------------------
   // synchronous update and reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         moving_reg <= smso_pkg::FLAG_RESET;
         heading_reg <= smso_pkg::FLAG_RESET;
      end else begin
         moving_reg <= moving_next;
         heading_reg <= heading_next;
      end
   end

endmodule : smso_shaft_track

`default_nettype wire

// ===== smso_status_out.sv
// shaft motion status block with apb register access
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - shaft count shown as unsigned binary in low four bits of count byte
// - moving flags for shafts one to five in bits zero to four
// - a shaft's moving flag goes to one once it starts moving, if the shaft is within the configured count
// - a shaft's moving flag goes to zero once it stops
// - heading flags in bits zero to four, one forward, zero reverse
// - heading flag keeps last movement's value while the shaft stands
module smso_status_out (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] shaft_move_active,
   input wire logic [4:0] shaft_move_fwd,
   output logic [4:0] shaft_in_motion,
   output logic [4:0] shaft_heading,
   output logic [3:0] shaft_total_code
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic smso_hit(
      input logic [11:0] addr,
      input logic [11:0] off
   );
      smso_hit = (addr == off);
   endfunction : smso_hit

   function automatic logic [4:0] smso_count_mask(
      input logic [3:0] count
   );
      logic [4:0] mask;
      mask = 5'h00;
      for (int i = 0; i < smso_pkg::SHAFTS; i++) begin
         mask[i] = (4'(i) < count);
      end
      smso_count_mask = mask;
   endfunction : smso_count_mask

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   smso_pkg::smso_bus_state_type state_reg;
   smso_pkg::smso_bus_state_type state_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [4:0] moving_w;
   logic [4:0] heading_w;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire access_w = psel & penable;
   wire hit_motion_w = smso_hit(paddr, smso_pkg::OFF_MOTION);
   wire hit_heading_w = smso_hit(paddr, smso_pkg::OFF_HEADING);
   wire hit_count_w = smso_hit(paddr, smso_pkg::OFF_COUNT);
   wire hit_config_w = smso_hit(paddr, smso_pkg::OFF_CONFIG);
   wire mapped_w = hit_motion_w | hit_heading_w | hit_count_w | hit_config_w;
   wire start_w = access_w & (state_reg == smso_pkg::SMSO_IDLE);
   wire commit_w = access_w & (state_reg == smso_pkg::SMSO_ANSWER);
   wire cfg_write_w = commit_w & pwrite & hit_config_w;
   wire [4:0] shaft_mask_w = smso_count_mask(count_reg);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // moving flags in low five bits
   wire [31:0] rd_motion_w = {27'h0000000, moving_w};
   // heading flags in low five bits
   wire [31:0] rd_heading_w = {27'h0000000, heading_w};
   // configured count in low four bits
   wire [31:0] rd_count_w = {28'h0000000, count_reg};
   wire [31:0] rd_data_w =
      hit_motion_w ? rd_motion_w :
      hit_heading_w ? rd_heading_w :
      (hit_count_w | hit_config_w) ? rd_count_w :
      smso_pkg::DATA_ZERO;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   assign state_next = start_w ? smso_pkg::SMSO_ANSWER : smso_pkg::SMSO_IDLE;
   assign pready_next = start_w;
   assign pslverr_next = start_w & ~mapped_w;
   assign prdata_next = (start_w & ~pwrite) ? rd_data_w : smso_pkg::DATA_ZERO;
   // count taken from the write data
   assign count_next = cfg_write_w ?
      pwdata[smso_pkg::COUNT_LSB +: smso_pkg::COUNT_W] : count_reg;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= smso_pkg::SMSO_IDLE;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= smso_pkg::DATA_ZERO;
      end else begin
         state_reg <= state_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_reg <= smso_pkg::COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // ----------------------------------------------------------------
   // shaft flag tracker
   // ----------------------------------------------------------------
   smso_shaft_track u_track (
      .core_clk(core_clk),
      .reset(reset),
      .move_active(shaft_move_active),
      .move_fwd(shaft_move_fwd),
      .enable_mask(shaft_mask_w),
      .moving_reg(moving_w),
      .heading_reg(heading_w)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign shaft_in_motion = moving_w;
   assign shaft_heading = heading_w;
   assign shaft_total_code = count_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge core_clk);
   endclocking

   default disable iff (reset);

   wire [4:0] act_masked_w = shaft_move_active & shaft_mask_w;
   wire [4:0] act_w = shaft_move_active;
   wire [4:0] fwd_w = shaft_move_fwd;
   wire rd_count_start_w = start_w & ~pwrite & hit_count_w;
   wire rd_motion_start_w = start_w & ~pwrite & hit_motion_w;
   wire rd_heading_start_w = start_w & ~pwrite & hit_heading_w;
   wire [3:0] wr_count_w = pwdata[smso_pkg::COUNT_LSB +: smso_pkg::COUNT_W];

   sequence seq_request;
      access_w && !pready;
   endsequence

   sequence seq_answer;
      pready ##1 !pready;
   endsequence

   chk_count_write: assert property (
      cfg_write_w |=> shaft_total_code == $past(wr_count_w)
   ) else $error("shaft count not taken from write");

   chk_count_read: assert property (
      rd_count_start_w |=> pready && prdata == {28'h0000000, shaft_total_code}
   ) else $error("shaft count read mismatch");

   chk_motion_byte: assert property (
      rd_motion_start_w |=> pready && prdata[31:5] == 27'h0000000
         && prdata[4:0] == $past(moving_w)
   ) else $error("motion byte wrong");

   chk_move_start: assert property (
      ##1 1'b1 |-> (shaft_in_motion & $past(act_masked_w)) == $past(act_masked_w)
   ) else $error("moving flag missing after start");

   // moving flag drops after a stop
   chk_move_stop: assert property (
      ##1 1'b1 |-> (shaft_in_motion & ~$past(act_w)) == 5'h00
   ) else $error("moving flag stays after stop");

   chk_heading_track: assert property (
      ##1 1'b1 |-> ((shaft_heading ^ $past(fwd_w)) & $past(act_w)) == 5'h00
   ) else $error("heading does not follow direction");

   chk_heading_byte: assert property (
      rd_heading_start_w |=> pready && prdata == {27'h0000000, $past(heading_w)}
   ) else $error("heading byte wrong");

   chk_heading_hold: assert property (
      !$past(reset) |-> ((shaft_heading ^ $past(heading_w)) & ~$past(act_w)) == 5'h00
   ) else $error("heading changed while stopped");

   chk_reset_clear: assert property (
      $past(reset) |-> shaft_in_motion == 5'h00 && shaft_heading == 5'h00
   ) else $error("flags not cleared by reset");

   chk_bus_answer: assert property (
      seq_request |=> seq_answer
   ) else $error("bus answer not one cycle pulse");

   chk_bus_error: assert property (
      start_w && !mapped_w |=> pready && pslverr
   ) else $error("unmapped access not flagged");

   // ----------------------------------------------------------------
   // count, mask and bus answer checks
   // ----------------------------------------------------------------
   wire rd_config_start_w = start_w & ~pwrite & hit_config_w;
   wire ro_write_w = commit_w & pwrite & ~hit_config_w;
   wire [4:0] mask_off_w = ~shaft_mask_w;

   sequence seq_setup;
      psel && !penable;
   endsequence

   sequence seq_access;
      psel && penable && !pready;
   endsequence

   chk_config_read: assert property (
      rd_config_start_w |=> pready && prdata == {28'h0000000, shaft_total_code}
   ) else $error("config read mismatch");

   chk_count_keep: assert property (
      ro_write_w |=> shaft_total_code == $past(shaft_total_code)
   ) else $error("count changed by read-only write");

   // count moves only on a config write
   chk_count_stable: assert property (
      !cfg_write_w |=> $stable(shaft_total_code)
   ) else $error("count changed without write");

   chk_mask_limit: assert property (
      ##1 1'b1 |-> (shaft_in_motion & $past(mask_off_w)) == 5'h00
   ) else $error("unconfigured shaft shows motion");

   // moving flags equal last cycle's masked activity
   chk_motion_exact: assert property (
      ##1 1'b1 |-> shaft_in_motion == $past(act_masked_w)
   ) else $error("moving flags differ from activity");

   // count back to default after reset
   chk_reset_count: assert property (
      $past(reset) |-> shaft_total_code == smso_pkg::COUNT_RESET
   ) else $error("count not restored by reset");

   // answer outputs low outside an answer
   chk_bus_quiet: assert property (
      !start_w |=> !pready && !pslverr && prdata == smso_pkg::DATA_ZERO
   ) else $error("bus outputs active outside answer");

   // answer lasts one cycle
   chk_answer_single: assert property (
      pready |=> !pready
   ) else $error("answer longer than one cycle");

   // known offsets answer without error
   chk_bus_mapped: assert property (
      start_w && mapped_w |=> pready && !pslverr
   ) else $error("mapped access flagged as error");

   // write answers carry no data
   chk_write_zero: assert property (
      start_w && pwrite |=> prdata == smso_pkg::DATA_ZERO
   ) else $error("write answer carries data");

   // unmapped accesses return zero
   chk_unmapped_zero: assert property (
      start_w && !mapped_w |=> prdata == smso_pkg::DATA_ZERO
   ) else $error("unmapped access returns data");

   // setup then access gets an answer
   chk_bus_phases: assert property (
      seq_setup ##1 seq_access |=> pready
   ) else $error("access not answered");

endmodule : smso_status_out

`default_nettype wire

// ===== smso_plc_model.sv
// plc side apb read and write model
`timescale 1ns/1ps
`default_nettype none

module smso_plc_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic req,
   input wire logic req_write,
   input wire logic [11:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0000_0000,
   output logic [31:0] rdata = 32'h0000_0000,
   output logic err = 1'b0,
   output logic done = 1'b0
);
   always @(posedge core_clk) begin
      done <= 1'b0;
      if (reset) begin
         psel <= 1'b0;
         penable <= 1'b0;
      end else if (req && !psel) begin
         psel <= 1'b1;
         pwrite <= req_write;
         paddr <= req_addr;
         pwdata <= req_wdata;
      end else if (psel && !penable) begin
         penable <= 1'b1;
      end else if (penable && pready) begin
         // released data lines do not keep the last word
         psel <= 1'b0;
         penable <= 1'b0;
         pwdata <= ~pwdata;
         paddr <= ~paddr;
         pwrite <= ~pwrite;
         rdata <= prdata;
         err <= pslverr;
         done <= 1'b1;
      end
   end
endmodule : smso_plc_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the shaft motion status block
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {logic chk; logic [31:0] data; logic err;} smso_note_type;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [11:0] req_addr = 12'h000;
   logic [31:0] req_wdata = 32'h0000_0000;
   logic [4:0] act = 5'h00;
   logic [4:0] fwd = 5'h00;
   logic [4:0] exp_m;
   logic [4:0] exp_h;
   logic [3:0] cfg = 4'h5;
   wire logic psel, penable, pwrite, pready, pslverr, done, err;
   wire logic [11:0] paddr;
   wire logic [31:0] pwdata, prdata, rdata;
   wire logic [4:0] mot, hd, mask;
   wire logic [3:0] tot;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   int i;
   smso_note_type nt;
   smso_note_type notes[$];

   smso_status_out u_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .shaft_move_active(act),
      .shaft_move_fwd(fwd), .shaft_in_motion(mot), .shaft_heading(hd),
      .shaft_total_code(tot));
   smso_plc_model u_plc (.core_clk(core_clk), .reset(reset), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .rdata(rdata), .err(err), .done(done));

   initial forever #50 core_clk = ~core_clk;

   task automatic end_of_test;
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_flag(input logic [4:0] got, input logic [4:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: flags got %h expected %h", $time, got, exp);
      end
   endtask : check_flag

   task automatic check_count(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: count got %h expected %h", $time, got, exp);
      end
   endtask : check_count

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic chk, input logic [31:0] e, input logic er);
      notes.push_back(smso_note_type'{chk, e, er});
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req <= 1'b1;
      @(posedge core_clk);
      req <= 1'b0;
      @(negedge core_clk);
      while (done !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
   endtask : bus

   // ----------------------------------------------------------------
   // flag model, bus watcher, timeout
   // ----------------------------------------------------------------
   assign mask = (cfg >= 4'h5) ? 5'h1F : ((5'h01 << cfg) - 5'h01);
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (reset) begin
         exp_m <= 5'h00;
         exp_h <= 5'h00;
      end else begin
         exp_m <= act & mask;
         exp_h <= (act & fwd) | (~act & exp_h);
      end
      if (done === 1'b1) begin
         nt = notes.pop_front();
         if (nt.chk) check(rdata, nt.data);
         check({31'h0, err}, {31'h0, nt.err});
      end
      if (cycles == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   always @(negedge core_clk) begin
      if (!reset) begin
         check_flag(mot, exp_m);
         check_flag(hd, exp_h);
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(22710));
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      bus(1'b0, smso_pkg::OFF_MOTION, 32'h0, 1'b1, 32'h0, 1'b0);
      bus(1'b0, smso_pkg::OFF_HEADING, 32'h0, 1'b1, 32'h0, 1'b0);
      bus(1'b0, smso_pkg::OFF_COUNT, 32'h0, 1'b1, 32'h5, 1'b0);
      bus(1'b0, 12'h010, 32'h0, 1'b1, 32'h0, 1'b1);
      bus(1'b1, smso_pkg::OFF_MOTION, 32'hFFFF_FFFF, 1'b0, 32'h0, 1'b0);
      bus(1'b0, smso_pkg::OFF_MOTION, 32'h0, 1'b1, 32'h0, 1'b0);
      $display("test reset_and_map done");
      for (i = 0; i < 300; i++) begin
         act <= 5'($urandom);
         fwd <= 5'($urandom);
         @(posedge core_clk);
      end
      act <= 5'h15;
      repeat (2) @(posedge core_clk);
      bus(1'b0, smso_pkg::OFF_MOTION, 32'h0, 1'b1, {27'h0, exp_m}, 1'b0);
      bus(1'b0, smso_pkg::OFF_HEADING, 32'h0, 1'b1, {27'h0, exp_h}, 1'b0);
      act <= 5'h00;
      repeat (3) @(posedge core_clk);
      $display("test random_motion done");
      bus(1'b1, smso_pkg::OFF_CONFIG, 32'h3, 1'b0, 32'h0, 1'b0);
      cfg <= 4'h3;
      bus(1'b0, smso_pkg::OFF_COUNT, 32'h0, 1'b1, 32'h3, 1'b0);
      bus(1'b0, smso_pkg::OFF_CONFIG, 32'h0, 1'b1, 32'h3, 1'b0);
      check_count(tot, 4'h3);
      act <= 5'h1F;
      fwd <= 5'h1F;
      repeat (4) @(posedge core_clk);
      act <= 5'h00;
      repeat (2) @(posedge core_clk);
      bus(1'b1, smso_pkg::OFF_CONFIG, 32'h2, 1'b0, 32'h0, 1'b0);
      cfg <= 4'h2;
      check_count(tot, 4'h2);
      $display("test shaft_count done");
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      cfg <= 4'h5;
      repeat (2) @(posedge core_clk);
      check_count(tot, 4'h5);
      $display("test mid_reset done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
